// file: logic/lcdp_device.sv
// lcdp_device: display side of the host bus port plus its receive fifo
// assumes bus pins are synchronous to sys_clk; user side drains bytes with valid/ready
`timescale 1ns/100ps
`default_nettype none

module lcdp_fifo
  import lcdp_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
)
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  almost_full,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [CW-1:0]    count_reg;
  logic             push;
  logic             pop;

  assign in_ready    = (count_reg != CW'(DEPTH));
  assign out_valid   = (count_reg != '0);
  assign almost_full = (count_reg >= CW'(DEPTH - 2));
  assign out_data    = mem[rd_ptr_reg];
  assign push        = in_valid & in_ready;
  assign pop         = out_valid & out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end
endmodule // lcdp_fifo

module lcdp_device
  import lcdp_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // host bus pins
  lcdp_bus_if.device_end  bus,
  // received bytes
  output logic            rx_valid,
  input  wire logic       rx_ready,
  output logic [7:0]      rx_byte,
  output logic            rx_is_data,
  // value returned on host reads
  input  wire logic [7:0] read_byte
);
  logic       port_rst;
  logic       cs_ok;
  logic       cs_prev_reg;
  logic       rs_prev_reg;
  logic       ws_prev_reg;
  logic       scl_prev_reg;
  logic [7:0] d_prev_reg;
  logic       dcs_prev_reg;
  logic [6:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic       wr_80;
  logic       wr_68;
  logic       scl_rise;
  logic       rd_active;
  logic       push_valid;
  logic [8:0] push_data;
  logic       fifo_in_ready;
  logic       fifo_almost_full;
  logic       fifo_out_valid;
  logic       fifo_out_ready;
  logic [8:0] fifo_out_data;

  assign port_rst = sys_rst | ~bus.reset_input_pin_n;
  assign cs_ok    = ~bus.chip_select_low_active_n & bus.chip_select_high_active;

  // parallel 80: write strobe falling edge
  assign wr_80 = (bus.par_ser_select == PS_PARALLEL) & (bus.host_family_select == FAMILY_80)
                 & cs_ok & ws_prev_reg & ~bus.write_strobe_pin;
  // parallel 68: end of enable pulse with direction low, values held during pulse
  assign wr_68 = (bus.par_ser_select == PS_PARALLEL) & (bus.host_family_select == FAMILY_68)
                 & cs_prev_reg & rs_prev_reg & ~bus.read_strobe_pin & ~ws_prev_reg;
  // serial: rising clock edge on bit 6
  assign scl_rise = (bus.par_ser_select == PS_SERIAL) & cs_ok
                    & ~scl_prev_reg & bus.bus_d[SCL_BIT];

  // read drive window, never in serial mode
  assign rd_active = (bus.par_ser_select == PS_PARALLEL) & cs_ok
                     & ((bus.host_family_select == FAMILY_80) ? ~bus.read_strobe_pin
                        : (bus.read_strobe_pin & bus.write_strobe_pin));

  always_comb
  begin
    push_valid = 1'b0;
    push_data  = '0;
    if (wr_80)
    begin
      push_valid = 1'b1;
      push_data  = {bus.data_command_select, bus.bus_d};
    end
    else if (wr_68)
    begin
      push_valid = 1'b1;
      push_data  = {dcs_prev_reg, d_prev_reg};
    end
    else if (scl_rise && bit_cnt_reg == LAST_BIT)
    begin
      push_valid = 1'b1;
      push_data  = {bus.data_command_select, shift_reg, bus.bus_d[SI_BIT]};
    end
  end

  // pin history for edge detection
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      cs_prev_reg  <= 1'b0;
      rs_prev_reg  <= 1'b0;
      ws_prev_reg  <= 1'b1;
      scl_prev_reg <= 1'b1;
      d_prev_reg   <= BUS_IDLE;
      dcs_prev_reg <= 1'b0;
    end
    else
    begin
      cs_prev_reg  <= cs_ok;
      rs_prev_reg  <= bus.read_strobe_pin;
      ws_prev_reg  <= bus.write_strobe_pin;
      scl_prev_reg <= bus.bus_d[SCL_BIT];
      d_prev_reg   <= bus.bus_d;
      dcs_prev_reg <= bus.data_command_select;
    end
  end

  // serial shifter, msb first; deselect restarts the byte
  always_ff @(posedge sys_clk)
  begin
    if (port_rst || !cs_ok || bus.par_ser_select == PS_PARALLEL)
    begin
      shift_reg   <= '0;
      bit_cnt_reg <= '0;
    end
    else if (scl_rise)
    begin
      shift_reg   <= {shift_reg[5:0], bus.bus_d[SI_BIT]};
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // bus drive and back-pressure toward the host
  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      bus.dev_d_oe_n <= 1'b1;
      bus.dev_d_out  <= BUS_IDLE;
      bus.port_busy  <= 1'b0;
    end
    else
    begin
      bus.dev_d_oe_n <= ~rd_active;
      bus.dev_d_out  <= read_byte;
      bus.port_busy  <= fifo_almost_full;
    end
  end

  lcdp_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk     (sys_clk),
    .sys_rst     (port_rst),
    .in_valid    (push_valid),
    .in_ready    (fifo_in_ready),
    .in_data     (push_data),
    .almost_full (fifo_almost_full),
    .out_valid   (fifo_out_valid),
    .out_ready   (fifo_out_ready),
    .out_data    (fifo_out_data)
  );

  // output register stage
  assign fifo_out_ready = ~rx_valid | rx_ready;

  always_ff @(posedge sys_clk)
  begin
    if (port_rst)
    begin
      rx_valid   <= 1'b0;
      rx_byte    <= '0;
      rx_is_data <= 1'b0;
    end
    else if (fifo_out_ready)
    begin
      rx_valid   <= fifo_out_valid;
      rx_byte    <= fifo_out_data[7:0];
      rx_is_data <= fifo_out_data[8];
    end
  end
endmodule // lcdp_device

`default_nettype wire

// file: logic/lcdp_pkg.sv
// lcdp_pkg: constants shared by both ends of the display host bus port
// assumes a single 50 MHz system clock on both ends
`default_nettype none

package lcdp_pkg;

  // clock and bus timing, times in ns, counts in sys_clk cycles
  localparam int          CLK_MHZ      = 50;
  localparam int          T_SETUP_NS   = 40;
  localparam int          T_STROBE_NS  = 100;
  localparam int          T_HOLD_NS    = 40;
  localparam int          T_SCL_HALF_NS = 100;
  localparam logic [3:0]  SETUP_CYC    = 4'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0]  STROBE_CYC   = 4'((T_STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0]  HOLD_CYC     = 4'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [3:0]  SCL_CYC      = 4'((T_SCL_HALF_NS * CLK_MHZ + 999) / 1000);

  // pin encodings
  localparam logic        FAMILY_80    = 1'b0;
  localparam logic        FAMILY_68    = 1'b1;
  localparam logic        PS_SERIAL    = 1'b0;
  localparam logic        PS_PARALLEL  = 1'b1;
  localparam int          SI_BIT       = 7;
  localparam int          SCL_BIT      = 6;
  localparam logic [7:0]  BUS_IDLE     = 8'hff;
  localparam logic [2:0]  LAST_BIT     = 3'h7;

  // receive buffer
  localparam int          FIFO_WIDTH   = 9;
  localparam int          FIFO_DEPTH   = 16;

  typedef enum logic [2:0] {
    H_IDLE,
    H_SETUP,
    H_STROBE,
    H_HOLD,
    H_SER_LOW,
    H_SER_HIGH
  } lcdp_host_state_type;

endpackage

`default_nettype wire

// file: logic/lcdp_bus_if.sv
// lcdp_bus_if: pins between host and display port, data bus resolved here
// assumes both ends run on the same sys_clk; undriven bus reads as pulled high
`timescale 1ns/100ps
`default_nettype none

interface lcdp_bus_if;
  import lcdp_pkg::*;

  logic [7:0] host_d_out;
  logic       host_d_oe_n;
  logic [7:0] dev_d_out;
  logic       dev_d_oe_n;
  logic [7:0] bus_d;
  logic       data_command_select;
  logic       chip_select_low_active_n;
  logic       chip_select_high_active;
  logic       host_family_select;
  logic       par_ser_select;
  logic       read_strobe_pin;
  logic       write_strobe_pin;
  logic       reset_input_pin_n;
  logic       port_busy;

  // wire level from the enables
  assign bus_d = !dev_d_oe_n ? dev_d_out : (!host_d_oe_n ? host_d_out : BUS_IDLE);

  modport host_end (
    output host_d_out, host_d_oe_n, data_command_select, chip_select_low_active_n,
           chip_select_high_active, host_family_select, par_ser_select,
           read_strobe_pin, write_strobe_pin, reset_input_pin_n,
    input  bus_d, port_busy
  );

  modport device_end (
    output dev_d_out, dev_d_oe_n, port_busy,
    input  bus_d, data_command_select, chip_select_low_active_n, chip_select_high_active,
           host_family_select, par_ser_select, read_strobe_pin, write_strobe_pin,
           reset_input_pin_n
  );

endinterface

`default_nettype wire

// file: logic/lcdp_host.sv
// lcdp_host: microprocessor side, turns byte commands into bus cycles
// assumes cfg inputs stay steady while commands are in flight
`timescale 1ns/100ps
`default_nettype none

module lcdp_host
  import lcdp_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // host bus pins
  lcdp_bus_if.host_end    bus,
  // configuration
  input  wire logic       cfg_family,
  input  wire logic       cfg_parallel,
  // commands
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic       cmd_is_data,
  input  wire logic [7:0] cmd_byte,
  // read answers
  output logic            rsp_valid,
  output logic [7:0]      rsp_byte
);
  lcdp_host_state_type state_reg;
  logic [3:0] timer_reg;
  logic       read_reg;
  logic [7:0] shift_reg;
  logic [2:0] bit_reg;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_reg                    <= H_IDLE;
      timer_reg                    <= '0;
      read_reg                     <= 1'b0;
      shift_reg                    <= '0;
      bit_reg                      <= '0;
      cmd_ready                    <= 1'b0;
      rsp_valid                    <= 1'b0;
      rsp_byte                     <= '0;
      bus.host_d_out               <= BUS_IDLE;
      bus.host_d_oe_n              <= 1'b1;
      bus.data_command_select      <= 1'b0;
      bus.chip_select_low_active_n <= 1'b1;
      bus.chip_select_high_active  <= 1'b0;
      bus.host_family_select       <= FAMILY_80;
      bus.par_ser_select           <= PS_PARALLEL;
      bus.read_strobe_pin          <= 1'b1;
      bus.write_strobe_pin         <= 1'b1;
      bus.reset_input_pin_n        <= 1'b1;
    end
    else
    begin
      rsp_valid <= 1'b0;
      timer_reg <= timer_reg - 4'h1;
      case (state_reg)
        H_IDLE:
        begin
          bus.host_family_select       <= cfg_family;
          bus.par_ser_select           <= cfg_parallel;
          bus.chip_select_low_active_n <= 1'b1;
          bus.chip_select_high_active  <= 1'b0;
          bus.host_d_oe_n              <= 1'b1;
          bus.read_strobe_pin          <= (cfg_family == FAMILY_68) ? 1'b0 : 1'b1;
          bus.write_strobe_pin         <= 1'b1;
          cmd_ready                    <= ~bus.port_busy;
          if (cmd_valid && cmd_ready && !(cmd_read && cfg_parallel == PS_SERIAL))
          begin
            cmd_ready                    <= 1'b0;
            read_reg                     <= cmd_read;
            shift_reg                    <= {cmd_byte[6:0], 1'b0};
            bit_reg                      <= '0;
            bus.chip_select_low_active_n <= 1'b0;
            bus.chip_select_high_active  <= 1'b1;
            bus.data_command_select      <= cmd_is_data;
            bus.host_d_oe_n              <= cmd_read;
            bus.host_d_out               <= (cfg_parallel == PS_SERIAL)
                                            ? {cmd_byte[7], 1'b0, 6'h3f} : cmd_byte;
            bus.write_strobe_pin         <= (cfg_family == FAMILY_68) ? cmd_read : 1'b1;
            timer_reg                    <= SETUP_CYC - 4'h1;
            state_reg                    <= H_SETUP;
          end
        end
        H_SETUP:
        begin
          if (timer_reg == 4'h0)
          begin
            if (bus.par_ser_select == PS_SERIAL)
            begin
              bus.host_d_out[SCL_BIT] <= 1'b1;
              timer_reg               <= SCL_CYC - 4'h1;
              state_reg               <= H_SER_HIGH;
            end
            else
            begin
              if (bus.host_family_select == FAMILY_68)
              begin
                bus.read_strobe_pin <= 1'b1;
              end
              else if (read_reg)
              begin
                bus.read_strobe_pin <= 1'b0;
              end
              else
              begin
                bus.write_strobe_pin <= 1'b0;
              end
              timer_reg <= STROBE_CYC - 4'h1;
              state_reg <= H_STROBE;
            end
          end
        end
        H_STROBE:
        begin
          if (timer_reg == 4'h0)
          begin
            if (read_reg)
            begin
              rsp_valid <= 1'b1;
              rsp_byte  <= bus.bus_d;
            end
            bus.read_strobe_pin  <= (bus.host_family_select == FAMILY_68) ? 1'b0 : 1'b1;
            bus.write_strobe_pin <= (bus.host_family_select == FAMILY_68) ? read_reg : 1'b1;
            timer_reg            <= HOLD_CYC - 4'h1;
            state_reg            <= H_HOLD;
          end
        end
        H_SER_HIGH:
        begin
          if (timer_reg == 4'h0)
          begin
            if (bit_reg == LAST_BIT)
            begin
              timer_reg <= HOLD_CYC - 4'h1;
              state_reg <= H_HOLD;
            end
            else
            begin
              bit_reg                 <= bit_reg + 3'h1;
              bus.host_d_out[SCL_BIT] <= 1'b0;
              bus.host_d_out[SI_BIT]  <= shift_reg[7];
              shift_reg               <= {shift_reg[6:0], 1'b0};
              timer_reg               <= SCL_CYC - 4'h1;
              state_reg               <= H_SER_LOW;
            end
          end
        end
        H_SER_LOW:
        begin
          if (timer_reg == 4'h0)
          begin
            bus.host_d_out[SCL_BIT] <= 1'b1;
            timer_reg               <= SCL_CYC - 4'h1;
            state_reg               <= H_SER_HIGH;
          end
        end
        H_HOLD:
        begin
          if (timer_reg == 4'h0)
          begin
            bus.chip_select_low_active_n <= 1'b1;
            bus.chip_select_high_active  <= 1'b0;
            bus.host_d_oe_n              <= 1'b1;
            bus.write_strobe_pin         <= 1'b1;
            state_reg                    <= H_IDLE;
          end
        end
        default:
        begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end
endmodule // lcdp_host

`default_nettype wire

// file: bench/lcdp_bus_sva.sv
// lcdp_bus_sva: concurrent checks on the pins between host and display port
// assumes one sys_clk domain; inputs are plain copies of lcdp_bus_if signals
`timescale 1ns/100ps
`default_nettype none

module lcdp_bus_sva
  import lcdp_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  // bus pins
  input wire logic [7:0] bus_d,
  input wire logic       host_d_oe_n,
  input wire logic       dev_d_oe_n,
  input wire logic       data_command_select,
  input wire logic       chip_select_low_active_n,
  input wire logic       chip_select_high_active,
  input wire logic       host_family_select,
  input wire logic       par_ser_select,
  input wire logic       read_strobe_pin,
  input wire logic       write_strobe_pin
);
  logic cs_on;
  assign cs_on = !chip_select_low_active_n && chip_select_high_active;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_drive_needs_read;
    !dev_d_oe_n |-> ((host_family_select == FAMILY_80) ? (!$past(read_strobe_pin) || !$past(read_strobe_pin, 2))
                                                       : ($past(read_strobe_pin) || $past(read_strobe_pin, 2)));
  endproperty
  a_drive_needs_read: assert property (p_drive_needs_read) else $error("device drives bus with no read");
  property p_read_gets_drive;
    (cs_on && !read_strobe_pin && host_family_select == FAMILY_80 && par_ser_select == PS_PARALLEL)[*3]
      |-> !dev_d_oe_n;
  endproperty
  a_read_gets_drive: assert property (p_read_gets_drive) else $error("read strobe low but bus not driven");
  property p_no_contention;
    !host_d_oe_n |-> dev_d_oe_n;
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("both ends drive the data bus");
  property p_write_data_steady;
    (cs_on && !write_strobe_pin && host_family_select == FAMILY_80 && par_ser_select == PS_PARALLEL)
      |-> !host_d_oe_n && $stable(bus_d);
  endproperty
  a_write_data_steady: assert property (p_write_data_steady) else $error("write data moves under strobe");
  property p_enable_pulse;
    $rose(read_strobe_pin) && host_family_select == FAMILY_68 && $past(host_family_select) == FAMILY_68
      |-> read_strobe_pin[*5] ##1 !read_strobe_pin;
  endproperty
  a_enable_pulse: assert property (p_enable_pulse) else $error("enable pulse width wrong");
  property p_68_read_hands_off;
    (host_family_select == FAMILY_68 && par_ser_select == PS_PARALLEL && cs_on && write_strobe_pin) |-> host_d_oe_n;
  endproperty
  a_68_read_hands_off: assert property (p_68_read_hands_off) else $error("host drives during read");
  property p_serial_never_drives;
    (par_ser_select == PS_SERIAL && $past(par_ser_select) == PS_SERIAL) |-> dev_d_oe_n;
  endproperty
  a_serial_never_drives: assert property (p_serial_never_drives) else $error("device drives in serial mode");
  property p_serial_clock_high;
    $rose(bus_d[SCL_BIT]) && cs_on && $past(cs_on) && par_ser_select == PS_SERIAL |-> bus_d[SCL_BIT][*5];
  endproperty
  a_serial_clock_high: assert property (p_serial_clock_high) else $error("serial clock high too short");
  property p_deselect_releases;
    (!cs_on)[*2] |-> dev_d_oe_n;
  endproperty
  a_deselect_releases: assert property (p_deselect_releases) else $error("bus driven while deselected");
  property p_select_steady;
    cs_on && $past(cs_on) |-> $stable(data_command_select);
  endproperty
  a_select_steady: assert property (p_select_steady) else $error("data/command select moved mid transfer");
endmodule // lcdp_bus_sva

`default_nettype wire

// file: bench/testbench.sv
// testbench: host and display port joined by lcdp_bus_if, plus a bench-driven second port
// assumes 50 MHz sys_clk, synchronous active-high reset, bench drives inputs on falling edges
`timescale 1ns/100ps
`default_nettype none

module testbench
  import lcdp_pkg::*;
;
  logic       sys_clk, sys_rst, cfg_family, cfg_parallel, cmd_valid, cmd_read, cmd_is_data;
  logic [7:0] cmd_byte, read_byte, rsp_byte, rx_byte, rx2_byte;
  logic       cmd_ready, rsp_valid, rx_valid, rx_is_data, rx2_valid, rx2_is_data;
  logic       rx_ready = 1'b0;
  logic       hold_rx = 1'b0;
  logic [8:0] rx_q[$], rx2_q[$];
  logic [7:0] rsp_q[$];
  int         n_fail, n_checks, n_taken;

  lcdp_bus_if bus();
  lcdp_bus_if bus2();
  lcdp_host lcdp_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .cfg_family(cfg_family),
    .cfg_parallel(cfg_parallel), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
    .cmd_is_data(cmd_is_data), .cmd_byte(cmd_byte), .rsp_valid(rsp_valid), .rsp_byte(rsp_byte));
  lcdp_device lcdp_device_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_is_data(rx_is_data), .read_byte(read_byte));
  lcdp_device lcdp_device_inst2 (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus2), .rx_valid(rx2_valid),
    .rx_ready(1'b1), .rx_byte(rx2_byte), .rx_is_data(rx2_is_data), .read_byte(8'h00));
  lcdp_bus_sva lcdp_bus_sva_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_d(bus.bus_d),
    .host_d_oe_n(bus.host_d_oe_n), .dev_d_oe_n(bus.dev_d_oe_n), .data_command_select(bus.data_command_select),
    .chip_select_low_active_n(bus.chip_select_low_active_n), .chip_select_high_active(bus.chip_select_high_active),
    .host_family_select(bus.host_family_select), .par_ser_select(bus.par_ser_select),
    .read_strobe_pin(bus.read_strobe_pin), .write_strobe_pin(bus.write_strobe_pin));

  task automatic complete_run;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one host command; the model records what the far end must show
  task automatic send(input logic rd, input logic dat, input logic [7:0] b);
    int k;
    k = 0;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_is_data = dat;
    cmd_byte = b;
    while (cmd_ready !== 1'b1 && k < 3000)
    begin
      @(negedge sys_clk);
      k++;
    end
    check(9'(k < 3000), 9'h001);
    read_byte = 8'($urandom);
    if (rd && cfg_parallel == PS_PARALLEL)
      rsp_q.push_back(read_byte);
    if (!rd)
      rx_q.push_back({dat, b});
    n_taken++;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask

  task automatic wait_idle;
    while (cmd_ready !== 1'b1)
      @(negedge sys_clk);
  endtask

  // bench-driven 80-series write on the second port with chosen selects
  task automatic wr2(input logic csl_n, input logic csh, input logic [7:0] b);
    // record before the strobe: the port shows the byte well before this task ends
    if (!csl_n && csh)
      rx2_q.push_back({1'b1, b});
    @(negedge sys_clk);
    bus2.chip_select_low_active_n = csl_n;
    bus2.chip_select_high_active = csh;
    bus2.host_d_out = b;
    bus2.host_d_oe_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    bus2.write_strobe_pin = 1'b0;
    repeat (5) @(negedge sys_clk);
    bus2.write_strobe_pin = 1'b1;
    repeat (2) @(negedge sys_clk);
    bus2.chip_select_low_active_n = 1'b1;
    bus2.chip_select_high_active = 1'b0;
    bus2.host_d_oe_n = 1'b1;
    bus2.host_d_out = ~b;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(negedge sys_clk)
    rx_ready <= hold_rx ? 1'b0 : 1'($urandom % 2);

  // result monitors against the model queues
  always @(posedge sys_clk)
  begin
    if (!sys_rst && rx_valid === 1'b1 && rx_ready === 1'b1)
      check({rx_is_data, rx_byte}, rx_q.size() > 0 ? rx_q.pop_front() : 9'bx);
    if (!sys_rst && rx2_valid === 1'b1)
      check({rx2_is_data, rx2_byte}, rx2_q.size() > 0 ? rx2_q.pop_front() : 9'bx);
    if (!sys_rst && rsp_valid === 1'b1)
      check({1'b0, rsp_byte}, rsp_q.size() > 0 ? {1'b0, rsp_q.pop_front()} : 9'bx);
  end

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_fail++;
    complete_run;
  end

  initial
  begin
    void'($urandom(75));
    sys_rst = 1'b1;
    {cfg_family, cfg_parallel} = {FAMILY_80, PS_PARALLEL};
    {cmd_valid, cmd_read, cmd_is_data, cmd_byte, read_byte} = '0;
    bus2.host_d_out = 8'h00;
    bus2.host_d_oe_n = 1'b1;
    bus2.data_command_select = 1'b1;
    bus2.chip_select_low_active_n = 1'b1;
    bus2.chip_select_high_active = 1'b0;
    bus2.host_family_select = FAMILY_80;
    bus2.par_ser_select = PS_PARALLEL;
    bus2.read_strobe_pin = 1'b1;
    bus2.write_strobe_pin = 1'b1;
    bus2.reset_input_pin_n = 1'b1;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    sys_rst = 1'b0;
    // 80 parallel, 68 parallel, serial: random mixes plus bit-order edge bytes
    for (int m = 0; m < 3; m++)
    begin
      wait_idle;
      cfg_family = (m == 1) ? FAMILY_68 : FAMILY_80;
      cfg_parallel = (m == 2) ? PS_SERIAL : PS_PARALLEL;
      for (int i = 0; i < 12; i++)
        send(1'($urandom % 3 == 0), 1'($urandom % 2), 8'($urandom));
      send(1'b0, 1'b1, 8'h01);
      send(1'b0, 1'b0, 8'h80);
      send(1'b1, 1'b0, 8'h00);
    end
    // fill the receive buffer with the user side stalled, then drain
    wait_idle;
    {cfg_family, cfg_parallel} = {FAMILY_80, PS_PARALLEL};
    hold_rx = 1'b1;
    n_taken = 0;
    fork
      for (int i = 0; i < 20; i++)
        send(1'b0, 1'($urandom % 2), 8'($urandom));
      begin
        repeat (400) @(negedge sys_clk);
        check(9'(n_taken <= FIFO_DEPTH), 9'h001);
        check(9'(bus.port_busy), 9'h001);
        hold_rx = 1'b0;
      end
    join
    // second port: every select combination, only both active is taken
    for (int c = 0; c < 4; c++)
      wr2(c[1], c[0], 8'($urandom));
    repeat (300) @(negedge sys_clk);
    check(9'(rx_q.size()), 9'h000);
    check(9'(rsp_q.size()), 9'h000);
    check(9'(rx2_q.size()), 9'h000);
    complete_run;
  end
endmodule // testbench

`default_nettype wire
